// ### common/rfp_params.svh
`ifndef RFP_PARAMS_SVH
`define RFP_PARAMS_SVH

// Register indices; the bus byte address is four times the index.
`define RFP_IDX_RX_DOWN     14'h2204
`define RFP_IDX_RX_UP       14'h2205
`define RFP_IDX_TX_DOWN     14'h2206
`define RFP_IDX_TX_UP       14'h2207

// Receive-path bit positions, shared by the down and up registers.
`define RFP_BIT_LNA         7
`define RFP_BIT_RX_MIX      6
`define RFP_BIT_BB_AMP      5
`define RFP_BIT_RX_MIX_BUF  4
`define RFP_BIT_RX_RSVD     3
`define RFP_BIT_RX_LPF      2
`define RFP_BIT_GAIN_AMP    1
`define RFP_BIT_RX_ADC      0

// Transmit-path bit positions, shared by the down and up registers.
`define RFP_BIT_TX_UMIX_BUF 5
`define RFP_BIT_PA          3
`define RFP_LSB_TX_UMIX     1
`define RFP_MSB_TX_UMIX     2
`define RFP_BIT_TX_DAC      0

// Reset values.
`define RFP_RST_RX_DOWN     8'h00
`define RFP_RST_RX_UP       8'hFF
`define RFP_RST_TX_DOWN     8'hD0
`define RFP_RST_TX_UP       8'hFF

// Transmit reserved bits are read-only and keep their reset level.
`define RFP_TX_RSVD_MASK    8'hD0

// Pair codes for the two-bit decoder.
`define RFP_CODE_SET        2'h3
`define RFP_CODE_CLR        2'h0

`endif

// ### common/rfp_pkg.sv
package rfp_pkg;

   // One bit per analogue circuit, receive circuits first.
   typedef struct packed {
      logic lna;
      logic rx_mix;
      logic bb_amp;
      logic rx_mix_buf;
      logic rx_lpf;
      logic gain_amp;
      logic rx_adc;
      logic tx_umix_buf;
      logic pa;
      logic tx_umix;
      logic tx_dac;
   } rfp_circ_t;

   typedef enum logic [1:0] {
      RFP_MODE_ON    = 2'h0,
      RFP_MODE_OFF   = 2'h1,
      RFP_MODE_MODEM = 2'h2
   } rfp_mode_t;

   typedef struct packed {
      logic wr_rx_dn;
      logic wr_rx_up;
      logic wr_tx_dn;
      logic wr_tx_up;
      logic rd_rx_dn;
      logic rd_rx_up;
      logic rd_tx_dn;
      logic rd_tx_up;
      logic req;
   } rfp_dec_t;

   typedef struct packed {
      logic [7:0] rx_dn;
      logic [7:0] rx_up;
      logic [7:0] tx_dn;
      logic [7:0] tx_up;
      logic       ack;
      logic [7:0] rdata;
      rfp_circ_t  en;
      rfp_circ_t  msel;
   } rfp_state_t;

endpackage

// ### src/rfp_pair_decode.sv
`timescale 1ns/1ps
`include "rfp_params.svh"

module rfp_pair_decode
(
   input  wire logic [1:0]        down_i,
   input  wire logic [1:0]        up_i,
   input  wire logic              modem_req_i,
   output rfp_pkg::rfp_mode_t     mode_o,
   output logic                   en_o
);

   // Reserved two-bit codes fall into the forced-on case, the safe side for a live circuit.
   always_comb
   begin
      if ((down_i == `RFP_CODE_SET) && (up_i == `RFP_CODE_SET))
      begin
         mode_o = rfp_pkg::RFP_MODE_MODEM;
      end
      else if ((down_i == `RFP_CODE_CLR) && (up_i == `RFP_CODE_SET))
      begin
         mode_o = rfp_pkg::RFP_MODE_OFF;
      end
      else
      begin
         mode_o = rfp_pkg::RFP_MODE_ON;
      end
      case (mode_o)
         rfp_pkg::RFP_MODE_MODEM: en_o = modem_req_i;
         rfp_pkg::RFP_MODE_OFF:   en_o = 1'h0;
         rfp_pkg::RFP_MODE_ON:    en_o = 1'h1;
         default:                 en_o = 1'h0;
      endcase
   end

endmodule

// ### src/rfp_wb_decode.sv
`timescale 1ns/1ps
`include "rfp_params.svh"

module rfp_wb_decode
(
   input  wire logic [15:0]       adr_i,
   input  wire logic              cyc_i,
   input  wire logic              stb_i,
   input  wire logic              we_i,
   input  wire logic [3:0]        sel_i,
   input  wire logic              ack_r_i,
   output rfp_pkg::rfp_dec_t      dec_o
);

   logic [13:0] idx;
   logic        wr_ok;

   assign idx = adr_i[15:2];

   // A write lands on the edge that completes the handshake, so it is applied once only.
   assign wr_ok = cyc_i && stb_i && we_i && sel_i[0] && ack_r_i;

   always_comb
   begin
      dec_o          = '0;
      dec_o.req      = cyc_i && stb_i;
      dec_o.rd_rx_dn = (idx == `RFP_IDX_RX_DOWN);
      dec_o.rd_rx_up = (idx == `RFP_IDX_RX_UP);
      dec_o.rd_tx_dn = (idx == `RFP_IDX_TX_DOWN);
      dec_o.rd_tx_up = (idx == `RFP_IDX_TX_UP);
      dec_o.wr_rx_dn = wr_ok && dec_o.rd_rx_dn;
      dec_o.wr_rx_up = wr_ok && dec_o.rd_rx_up;
      dec_o.wr_tx_dn = wr_ok && dec_o.rd_tx_dn;
      dec_o.wr_tx_up = wr_ok && dec_o.rd_tx_up;
   end

endmodule

// ### src/rfp_regs.sv
// Summary of operation
// RQ1: Receive mixer buffer enable decodes its down/up pair: both set modem, 0/1 off, else on.
// RQ2: Receive low-pass filter enable uses the same pair decoding.
// RQ3: Receive mixer enable uses the same pair decoding.
// RQ4: Baseband amplifier enable uses the same pair decoding.
// RQ5: Variable-gain amplifier enable uses the same pair decoding.
// RQ6: Receive converter enable uses the same pair decoding.
// RQ7: Software keeps receive power-down bit 3 at zero.
// RQ8: Software keeps receive power-up bit 3 at one.
// RQ9: Transmit up-mixer buffer enable decodes bit 5 of both transmit registers.
// RQ10: Power amplifier enable decodes bit 3 of both transmit registers.
// RQ11: Up-mixer two-bit fields: 3/3 modem, 3/0 on, 0/3 off, 0/0 on.
// RQ12: Software writes only 0 or 3 into the up-mixer fields.
// RQ13: Transmit converter enable decodes bit 0; forced off drops its enable.
// RQ14: Low-noise amplifier enable decodes bit 7 of both receive registers.
// RQ15: In modem control an enable follows the modem's request for that circuit.
// RQ16: After reset every pair is down 0, up 1, so all enables are off.
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "rfp_params.svh"

module rfp_regs
(
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              ce_i,
   input  wire logic [15:0]       adr_i,
   input  wire logic [31:0]       dat_i,
   input  wire logic              we_i,
   input  wire logic [3:0]        sel_i,
   input  wire logic              cyc_i,
   input  wire logic              stb_i,
   output logic      [31:0]       dat_o,
   output logic                   ack_o,
   input  rfp_pkg::rfp_circ_t     modem_req_i,
   output rfp_pkg::rfp_circ_t     circ_en_o,
   output rfp_pkg::rfp_circ_t     modem_sel_o
);

   localparam int NCIRC = 11;

   rfp_pkg::rfp_state_t           st_r;
   rfp_pkg::rfp_state_t           st_nxt;
   rfp_pkg::rfp_dec_t             dec;
   logic [NCIRC-1:0][1:0]         pair_dn;
   logic [NCIRC-1:0][1:0]         pair_up;
   logic [NCIRC-1:0]              req_vec;
   logic [NCIRC-1:0]              en_vec;
   logic [NCIRC-1:0]              sel_vec;
   rfp_pkg::rfp_mode_t            mode_vec [NCIRC];

   rfp_wb_decode u_dec
   (
      .adr_i   (adr_i),
      .cyc_i   (cyc_i),
      .stb_i   (stb_i),
      .we_i    (we_i),
      .sel_i   (sel_i),
      .ack_r_i (st_r.ack),
      .dec_o   (dec)
   );

   // Single-bit pairs are widened by replication, so one two-bit decoder serves every circuit.
   always_comb
   begin
      pair_dn[10] = {2{st_r.rx_dn[`RFP_BIT_LNA]}};                       // [RQ14]
      pair_up[10] = {2{st_r.rx_up[`RFP_BIT_LNA]}};                       // [RQ14]
      pair_dn[9]  = {2{st_r.rx_dn[`RFP_BIT_RX_MIX]}};                    // [RQ3]
      pair_up[9]  = {2{st_r.rx_up[`RFP_BIT_RX_MIX]}};                    // [RQ3]
      pair_dn[8]  = {2{st_r.rx_dn[`RFP_BIT_BB_AMP]}};                    // [RQ4]
      pair_up[8]  = {2{st_r.rx_up[`RFP_BIT_BB_AMP]}};                    // [RQ4]
      pair_dn[7]  = {2{st_r.rx_dn[`RFP_BIT_RX_MIX_BUF]}};                // [RQ1]
      pair_up[7]  = {2{st_r.rx_up[`RFP_BIT_RX_MIX_BUF]}};                // [RQ1]
      pair_dn[6]  = {2{st_r.rx_dn[`RFP_BIT_RX_LPF]}};                    // [RQ2]
      pair_up[6]  = {2{st_r.rx_up[`RFP_BIT_RX_LPF]}};                    // [RQ2]
      pair_dn[5]  = {2{st_r.rx_dn[`RFP_BIT_GAIN_AMP]}};                  // [RQ5]
      pair_up[5]  = {2{st_r.rx_up[`RFP_BIT_GAIN_AMP]}};                  // [RQ5]
      pair_dn[4]  = {2{st_r.rx_dn[`RFP_BIT_RX_ADC]}};                    // [RQ6]
      pair_up[4]  = {2{st_r.rx_up[`RFP_BIT_RX_ADC]}};                    // [RQ6]
      pair_dn[3]  = {2{st_r.tx_dn[`RFP_BIT_TX_UMIX_BUF]}};               // [RQ9]
      pair_up[3]  = {2{st_r.tx_up[`RFP_BIT_TX_UMIX_BUF]}};               // [RQ9]
      pair_dn[2]  = {2{st_r.tx_dn[`RFP_BIT_PA]}};                        // [RQ10]
      pair_up[2]  = {2{st_r.tx_up[`RFP_BIT_PA]}};                        // [RQ10]
      pair_dn[1]  = st_r.tx_dn[`RFP_MSB_TX_UMIX:`RFP_LSB_TX_UMIX];       // [RQ11]
      pair_up[1]  = st_r.tx_up[`RFP_MSB_TX_UMIX:`RFP_LSB_TX_UMIX];       // [RQ11]
      pair_dn[0]  = {2{st_r.tx_dn[`RFP_BIT_TX_DAC]}};                    // [RQ13]
      pair_up[0]  = {2{st_r.tx_up[`RFP_BIT_TX_DAC]}};                    // [RQ13]
   end

   assign req_vec = modem_req_i;

   generate
      for (genvar g = 0; g < NCIRC; g++)
      begin : g_circ
         // Codes 1 and 2 of the up-mixer fields decode as forced on. [RQ12]
         rfp_pair_decode u_pair
         (
            .down_i      (pair_dn[g]),
            .up_i        (pair_up[g]),
            .modem_req_i (req_vec[g]),
            .mode_o      (mode_vec[g]),
            .en_o        (en_vec[g])
         );
         // The modem request only reaches the circuit when its pair hands over control. [RQ15]
         assign sel_vec[g] = (mode_vec[g] == rfp_pkg::RFP_MODE_MODEM);
      end
   endgenerate

   always_comb
   begin
      st_nxt = st_r;
      // Ack is a one-cycle pulse, so a held strobe is not acknowledged on two successive cycles.
      st_nxt.ack = dec.req && !st_r.ack;
      if (dec.req && !st_r.ack)
      begin
         if (dec.rd_rx_dn)
         begin
            st_nxt.rdata = st_r.rx_dn;
         end
         else if (dec.rd_rx_up)
         begin
            st_nxt.rdata = st_r.rx_up;
         end
         else if (dec.rd_tx_dn)
         begin
            st_nxt.rdata = st_r.tx_dn;
         end
         else if (dec.rd_tx_up)
         begin
            st_nxt.rdata = st_r.tx_up;
         end
         else
         begin
            st_nxt.rdata = 8'h00;
         end
      end
      // Reserved receive bit 3 stays writable; software is trusted to keep it. [RQ7] [RQ8]
      if (dec.wr_rx_dn)
      begin
         st_nxt.rx_dn = dat_i[7:0];
      end
      if (dec.wr_rx_up)
      begin
         st_nxt.rx_up = dat_i[7:0];
      end
      if (dec.wr_tx_dn)
      begin
         st_nxt.tx_dn = (dat_i[7:0] & ~`RFP_TX_RSVD_MASK) | (`RFP_RST_TX_DOWN & `RFP_TX_RSVD_MASK);
      end
      if (dec.wr_tx_up)
      begin
         st_nxt.tx_up = (dat_i[7:0] & ~`RFP_TX_RSVD_MASK) | (`RFP_RST_TX_UP & `RFP_TX_RSVD_MASK);
      end
      // A forced-off pair clears the enable, so the converter draws no current. [RQ13]
      st_nxt.en   = en_vec;                                              // [RQ15]
      st_nxt.msel = sel_vec;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_r       <= '0;
         st_r.rx_dn <= `RFP_RST_RX_DOWN;                                 // [RQ16]
         st_r.rx_up <= `RFP_RST_RX_UP;                                   // [RQ16]
         st_r.tx_dn <= `RFP_RST_TX_DOWN;                                 // [RQ16]
         st_r.tx_up <= `RFP_RST_TX_UP;                                   // [RQ16]
      end
      else if (ce_i)
      begin
         st_r <= st_nxt;
      end
   end

   assign dat_o       = {24'h000000, st_r.rdata};
   assign ack_o       = st_r.ack;
   assign circ_en_o   = st_r.en;
   assign modem_sel_o = st_r.msel;

endmodule

// ### tb/rfp_modem_model.sv
`timescale 1ns/1ps

module rfp_modem_model
(
   input  wire logic [1:0]        phase_i,
   input  wire logic              clk_i,
   output rfp_pkg::rfp_circ_t     req_o
);
   // Phase 1 is reception and phase 2 transmission; only the active path is requested.
   always_ff @(posedge clk_i)
   begin
      req_o <= (phase_i == 2'h1) ? 11'h7F0 : (phase_i == 2'h2) ? 11'h00F : 11'h000;
   end
endmodule

// ### tb/rfp_regs_sva.sv
`timescale 1ns/1ps

module rfp_regs_sva
(
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              ce_i,
   input  wire logic              cyc_i,
   input  wire logic              stb_i,
   input  wire logic [31:0]       dat_o,
   input  wire logic              ack_o,
   input  rfp_pkg::rfp_circ_t     modem_req_i,
   input  rfp_pkg::rfp_circ_t     circ_en_o,
   input  rfp_pkg::rfp_circ_t     modem_sel_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_taken;
      cyc_i && stb_i && ce_i && !ack_o;
   endsequence

   sequence s_ack_live;
      ack_o && ce_i;
   endsequence

   chk_ack_follows: assert property (s_taken |=> ack_o)
      else $error("ack did not follow a taken request");
   chk_ack_single: assert property (s_ack_live |=> !ack_o)
      else $error("ack lasted more than one cycle");
   chk_ack_idle: assert property (ce_i && !(cyc_i && stb_i) |=> !ack_o)
      else $error("ack without a request");
   chk_freeze_all: assert property (!ce_i |=>
      $stable(circ_en_o) && $stable(modem_sel_o) && $stable(ack_o) && $stable(dat_o))
      else $error("state moved while clock enable was low");
   chk_data_hold: assert property (!(cyc_i && stb_i && ce_i && !ack_o) |=> $stable(dat_o))
      else $error("read data changed without a request");
   chk_upper_zero: assert property (dat_o[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   chk_reset_off: assert property ($past(rst_i) |-> circ_en_o == '0 && modem_sel_o == '0)
      else $error("enables not off after reset");
   chk_modem_follow: assert property (ce_i |=>
      ((circ_en_o ^ $past(modem_req_i)) & modem_sel_o) == '0)
      else $error("modem controlled enable does not follow the request");
endmodule

bind rfp_regs rfp_regs_sva u_sva
(
   .clk_i       (clk_i),
   .rst_i       (rst_i),
   .ce_i        (ce_i),
   .cyc_i       (cyc_i),
   .stb_i       (stb_i),
   .dat_o       (dat_o),
   .ack_o       (ack_o),
   .modem_req_i (modem_req_i),
   .circ_en_o   (circ_en_o),
   .modem_sel_o (modem_sel_o)
);

// ### tb/rfp_regs_tb.sv
`timescale 1ns/1ps
`include "rfp_params.svh"

module rfp_regs_tb;
   logic               clk_i;
   logic               rst_i;
   logic               ce_i;
   logic [15:0]        adr_i;
   logic [31:0]        dat_i;
   logic               we_i;
   logic [3:0]         sel_i;
   logic               cyc_i;
   logic               stb_i;
   logic [31:0]        dat_o;
   logic               ack_o;
   logic [1:0]         phase;
   rfp_pkg::rfp_circ_t req;
   rfp_pkg::rfp_circ_t circ_en_o;
   rfp_pkg::rfp_circ_t modem_sel_o;
   rfp_pkg::rfp_circ_t ex;
   logic [31:0]        r;
   logic [15:0]        adr_tbl [4];
   logic [7:0]         rst_tbl [4];
   logic               d;
   logic               u;
   int                 mismatches;
   int                 checks;

   rfp_regs u_dut
   (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .adr_i(adr_i), .dat_i(dat_i), .we_i(we_i),
      .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
      .modem_req_i(req), .circ_en_o(circ_en_o), .modem_sel_o(modem_sel_o)
   );

   rfp_modem_model u_modem
   (
      .phase_i(phase), .clk_i(clk_i), .req_o(req)
   );

   always #10 clk_i = ~clk_i;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   // The request is held until ack is sampled, then dropped for one idle cycle.
   task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] v,
                     input logic [3:0] s, output logic [31:0] rd);
      cyc_i <= 1'h1;
      stb_i <= 1'h1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= {24'h000000, v};
      sel_i <= s;
      @(posedge clk_i);
      // Only the watchdog ends a wait for an ack that never comes.
      while (ack_o !== 1'h1)
      begin
         @(posedge clk_i);
      end
      rd = dat_o;
      cyc_i <= 1'h0;
      stb_i <= 1'h0;
      we_i  <= 1'h0;
      @(posedge clk_i);
   endtask

   task automatic print_verdict;
      if (mismatches == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      #100000;
      mismatches++;
      print_verdict();
   end

   initial
   begin
      clk_i = 1'h0;
      rst_i = 1'h1;
      ce_i = 1'h1;
      {adr_i, dat_i, we_i, sel_i, cyc_i, stb_i} = '0;
      phase = 2'h0;
      mismatches = 0;
      checks = 0;
      adr_tbl = '{{`RFP_IDX_RX_DOWN, 2'h0}, {`RFP_IDX_RX_UP, 2'h0},
                  {`RFP_IDX_TX_DOWN, 2'h0}, {`RFP_IDX_TX_UP, 2'h0}};
      rst_tbl = '{`RFP_RST_RX_DOWN, `RFP_RST_RX_UP, `RFP_RST_TX_DOWN, `RFP_RST_TX_UP};
      repeat (3) @(posedge clk_i);
      rst_i <= 1'h0;
      @(posedge clk_i);
      chk(circ_en_o, 32'h0);
      chk(modem_sel_o, 32'h0);
      for (int i = 0; i < 4; i++)
      begin
         wb(1'h0, adr_tbl[i], 8'h00, 4'h0, r);
         chk(r, {24'h0, rst_tbl[i]});
      end
      // Each down/up combination of 0 and 1 (0 and 3 in the up-mixer fields) in turn, first with the modem receiving, then transmitting.
      for (int c = 0; c < 8; c++)
      begin
         d = c[1];
         u = c[0];
         phase <= (c < 4) ? 2'h1 : 2'h2;
         wb(1'h1, adr_tbl[0], d ? 8'hF7 : 8'h00, 4'h1, r);
         wb(1'h1, adr_tbl[1], u ? 8'hFF : 8'h08, 4'h1, r);
         wb(1'h1, adr_tbl[2], {8{d}}, 4'h1, r);
         wb(1'h1, adr_tbl[3], {8{u}}, 4'h1, r);
         repeat (2) @(posedge clk_i);
         ex = (d & u) ? ((c < 4) ? 11'h7F0 : 11'h00F) : (u ? 11'h000 : 11'h7FF);
         chk(circ_en_o, ex);
         chk(modem_sel_o, {21'h0, {11{d & u}}});
         wb(1'h0, adr_tbl[2], 8'h00, 4'h0, r);
         chk(r, {24'h0, {8{d}} | `RFP_TX_RSVD_MASK});
      end
      // A write without the low byte lane, and one to an unmapped place, change nothing.
      wb(1'h1, adr_tbl[0], 8'h55, 4'hE, r);
      wb(1'h0, adr_tbl[0], 8'h00, 4'h0, r);
      chk(r, 32'hF7);
      wb(1'h1, 16'h0000, 8'hAA, 4'h1, r);
      wb(1'h0, 16'h0000, 8'h00, 4'h0, r);
      chk(r, 32'h0);
      ce_i <= 1'h0;
      phase <= 2'h1;
      repeat (4) @(posedge clk_i);
      chk(circ_en_o, 32'h00F);
      ce_i <= 1'h1;
      repeat (3) @(posedge clk_i);
      chk(circ_en_o, 32'h7F0);
      // Adjacent circuits get different pair codes, so a pair wired to a neighbouring bit shows up.
      wb(1'h1, adr_tbl[0], 8'hA5, 4'h1, r);
      wb(1'h1, adr_tbl[1], 8'h6E, 4'h1, r);
      wb(1'h1, adr_tbl[2], 8'h0E, 4'h1, r);
      wb(1'h1, adr_tbl[3], 8'h29, 4'h1, r);
      repeat (2) @(posedge clk_i);
      chk(circ_en_o, 32'h5D2);
      chk(modem_sel_o, 32'h144);
      phase <= 2'h2;
      repeat (3) @(posedge clk_i);
      chk(circ_en_o, 32'h496);
      wb(1'h0, adr_tbl[3], 8'h00, 4'h0, r);
      chk(r, 32'hF9);
      print_verdict();
   end
endmodule
